// ### hss_sequencer.sv
// How it works
// - gate held off until supply above 6.0 V
// - reset releases after both internal supplies good
// - turn-on needs UV, OV in range, enable active
// - UV and enable stable 90.6 ms, change restarts
// - turn-on enables 50 uA gate pull-up
// - power good needs VDS, gate, feedback thresholds
// - startup pin low at power-up sets on bit
// - enable change starts normal turn-off
// - OV, UV, overcurrent, bad FET turn gate off
// - feedback below threshold releases power good
// - supply 5.5 V or 3.89 V low: fast shutdown
// - fault timer charges only during current limiting
// - timer 2.56 V: gate off, flag, fault low
// - after overcurrent discharge timer below 0.2 V
// - fault tied to UV retries after 9.28 s
// - limit 6 to 20 mV from pin or bits
// - high VDS folds limit back to 30%
// - three times limit pulls gate fast
// - sample 1 us, 12-bit result every 283 us
// - each result pair multiplied into power
// - min/max kept, 12-bit threshold alerts
// - temperature stored at 1 degree per step
// - two three-level pins give nine addresses
// - alerts disabled, no alert pin after reset
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "hss_map.svh"
module hss_sequencer #(
  parameter int DEBOUNCE_CYC = `HSS_DEBOUNCE_US * (1000 / `HSS_CLK_NS),
  parameter int COOLDOWN_CYC = `HSS_COOLDOWN_MS * (1000000 / `HSS_CLK_NS)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog comparators and straps
  input wire logic [`HSS_IN_WIDTH-1:0] comparator_in,
  // converters
  input wire logic adc_done,
  input wire logic [11:0] sense_result,
  input wire logic [11:0] vout_result,
  input wire logic [11:0] temp_result,
  output logic adc_sample_tick,
  output logic adc_frame_tick,
  // gate and timer drive
  output logic gate_pullup_en,
  output logic gate_pulldown_en,
  output logic gate_fast_pulldown_en,
  output logic timer_charge_en,
  output logic timer_discharge_en,
  output logic foldback_en,
  output logic [3:0] current_limit_code,
  // open-drain pins
  output logic power_good_pin_o,
  output logic power_good_pin_oe_b,
  output logic fault_pin_o,
  output logic fault_pin_oe_b,
  output logic alert_pin_o,
  output logic alert_pin_oe_b,
  // status
  output logic [6:0] bus_address
);
  localparam int SAMPLE_CYC = `HSS_SAMPLE_US * (1000 / `HSS_CLK_NS);
  localparam int FRAME_CYC = `HSS_FRAME_US * (1000 / `HSS_CLK_NS);
  function automatic logic [31:0] hss_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    return {strb[3] ? nw[31:24] : old[31:24], strb[2] ? nw[23:16] : old[23:16],
            strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction
  function automatic logic [23:0] hss_minmax(input logic [23:0] mm, input logic [11:0] v);
    return {(v > mm[23:12]) ? v : mm[23:12], (v < mm[11:0]) ? v : mm[11:0]};
  endfunction
  function automatic logic [1:0] hss_cross(input logic [31:0] th, input logic [11:0] v);
    return {v > th[27:16], v < th[11:0]};
  endfunction
  // input synchroniser, change counts once stages two and three agree
  logic [`HSS_IN_WIDTH-1:0] s1_r, s2_r, s3_r, in_r;
  wire [`HSS_IN_WIDTH-1:0] in_nxt = (s2_r & ~(s2_r ^ s3_r)) | (in_r & (s2_r ^ s3_r));
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      in_r <= '0;
    end else begin
      s1_r <= comparator_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      in_r <= in_nxt;
    end
  end
  wire vdd_ok = in_r[`HSS_IN_VDD_OK];
  wire uv_ok = in_r[`HSS_IN_UV];
  wire ov_high = in_r[`HSS_IN_OV];
  wire en_act = in_r[`HSS_IN_EN];
  wire por_ok = in_r[`HSS_IN_INTERNAL_REGULATED_SUPPLY_OK] & in_r[`HSS_IN_INTERNAL_LOGIC_SUPPLY_OK];
  wire fast_off = in_r[`HSS_IN_VDD_LOW] | in_r[`HSS_IN_INTERNAL_REGULATED_SUPPLY_LOW];
  wire bad_fet = in_r[`HSS_IN_BADFET];
  wire pg_cond = in_r[`HSS_IN_DS_LOW] & in_r[`HSS_IN_GATE_HIGH] & in_r[`HSS_IN_FB_OK];
  // straps caught once the internal supplies come up
  logic por_done_r;
  logic [2:0] current_set_pin_r;
  logic [6:0] addr_r;
  wire [1:0] adr_lo = in_r[`HSS_IN_ADRL_LSB +: 2];
  wire [1:0] adr_hi = in_r[`HSS_IN_ADRH_LSB +: 2];
  wire [6:0] addr_nxt = `HSS_ADDR_BASE + 7'(adr_hi) * 7'h3 + 7'(adr_lo);
  logic [31:0] ctrl_r, alcfg_r;
  logic [31:0] th_r [4];
  logic [23:0] mm_r [4];
  logic [1:0] flag_r;
  logic [7:0] alstat_r;
  logic [11:0] sense_r, vout_r, temp_r;
  logic [23:0] power_r;
  wire on_bit = ctrl_r[`HSS_CTRL_ON_BIT];
  // sequencer
  hss_pkg::hss_state_type st_r, st_nxt;
  logic [26:0] cnt_r;
  logic [1:0] snap_r;
  wire ready = por_ok & vdd_ok & uv_ok & ~ov_high & en_act & on_bit;
  wire deb_change = snap_r != {uv_ok, en_act};
  wire cnt_clear = (st_r != st_nxt) | (st_r == hss_pkg::HSS_DEBOUNCE && deb_change);
  wire run_fault = ov_high | ~uv_ok | ~vdd_ok | fast_off | ~en_act | ~on_bit | ~por_ok;
  wire tmr_trip = in_r[`HSS_IN_TMR_HIGH];
  wire gate_up = st_r == hss_pkg::HSS_RAMP || st_r == hss_pkg::HSS_ON;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      hss_pkg::HSS_OFF: begin
        if (ready) begin
          st_nxt = hss_pkg::HSS_DEBOUNCE;
        end
      end
      hss_pkg::HSS_DEBOUNCE: begin
        if (!ready) begin
          st_nxt = hss_pkg::HSS_OFF;
        end else if (!deb_change && cnt_r >= 27'(DEBOUNCE_CYC - 1)) begin
          st_nxt = hss_pkg::HSS_RAMP;
        end
      end
      hss_pkg::HSS_RAMP, hss_pkg::HSS_ON: begin
        if (tmr_trip || bad_fet) begin
          st_nxt = hss_pkg::HSS_TMR_DISCHARGE;
        end else if (run_fault) begin
          st_nxt = hss_pkg::HSS_OFF;
        end else if (st_r == hss_pkg::HSS_RAMP && pg_cond) begin
          st_nxt = hss_pkg::HSS_ON;
        end
      end
      hss_pkg::HSS_TMR_DISCHARGE: begin
        if (in_r[`HSS_IN_TMR_LOW]) begin
          st_nxt = hss_pkg::HSS_COOLDOWN;
        end
      end
      hss_pkg::HSS_COOLDOWN: begin
        if (cnt_r >= 27'(COOLDOWN_CYC - 1)) begin
          st_nxt = hss_pkg::HSS_OFF;
        end
      end
      default: st_nxt = hss_pkg::HSS_OFF;
    endcase
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= hss_pkg::HSS_OFF;
      cnt_r <= '0;
      snap_r <= '0;
    end else begin
      st_r <= por_done_r ? st_nxt : hss_pkg::HSS_OFF;
      cnt_r <= cnt_clear ? 27'h0 : cnt_r + 27'h1;
      snap_r <= {uv_ok, en_act};
    end
  end
  // converter pacing
  logic [3:0] samp_cnt_r;
  logic [11:0] frame_cnt_r;
  wire samp_end = samp_cnt_r == 4'(SAMPLE_CYC - 1);
  wire frame_end = frame_cnt_r == 12'(FRAME_CYC - 1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      samp_cnt_r <= '0;
      frame_cnt_r <= '0;
      adc_sample_tick <= 1'b0;
      adc_frame_tick <= 1'b0;
    end else begin
      samp_cnt_r <= samp_end ? 4'h0 : samp_cnt_r + 4'h1;
      frame_cnt_r <= frame_end ? 12'h0 : frame_cnt_r + 12'h1;
      adc_sample_tick <= samp_end;
      adc_frame_tick <= frame_end;
    end
  end
  // telemetry
  wire [23:0] power_nxt = sense_result * vout_result;
  wire [11:0] power_hi = power_nxt[23:12];
  wire [7:0] cross_nxt = {hss_cross(th_r[3], temp_result), hss_cross(th_r[2], power_hi),
                          hss_cross(th_r[1], sense_result), hss_cross(th_r[0], vout_result)};
  // bus decode
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  wire wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire [3:0] wi = awaddr_r[5:2] - 4'h9;
  wire wr_ctrl = wr_fire && awaddr_r == `HSS_CTRL_OFS;
  wire wr_stat = wr_fire && awaddr_r == `HSS_STAT_OFS;
  wire wr_alcfg = wr_fire && awaddr_r == `HSS_ALCFG_OFS;
  wire wr_alstat = wr_fire && awaddr_r == `HSS_ALSTAT_OFS;
  wire wr_th = wr_fire && awaddr_r >= `HSS_VOUT_TH_OFS && awaddr_r <= `HSS_TEMP_TH_OFS && awaddr_r[1:0] == 2'h0;
  wire wr_ok = wr_ctrl | wr_stat | wr_alcfg | wr_alstat | wr_th;
  wire [31:0] stat_clr = hss_merge(32'h0, wdata_r, wstrb_r);
  wire [1:0] flag_set = {bad_fet & gate_up, tmr_trip & gate_up};
  wire [3:0] ri = s_axi_araddr[5:2];
  wire [31:0] rd_val =
    s_axi_araddr == `HSS_CTRL_OFS ? ctrl_r :
    s_axi_araddr == `HSS_STAT_OFS ? {22'h0, flag_r, 4'h0, ~power_good_pin_oe_b, st_r} :
    s_axi_araddr == `HSS_ADDR_OFS ? {25'h0, addr_r} :
    s_axi_araddr == `HSS_ALCFG_OFS ? alcfg_r :
    s_axi_araddr == `HSS_ALSTAT_OFS ? {24'h0, alstat_r} :
    s_axi_araddr >= `HSS_VOUT_MM_OFS && s_axi_araddr <= `HSS_TEMP_MM_OFS ? {4'h0, mm_r[2'(ri - 4'h5)][23:12],
      4'h0, mm_r[2'(ri - 4'h5)][11:0]} :
    s_axi_araddr >= `HSS_VOUT_TH_OFS && s_axi_araddr <= `HSS_TEMP_TH_OFS ? th_r[2'(ri - 4'h9)] :
    s_axi_araddr == `HSS_MEAS_OFS ? {temp_r[7:0], vout_r, sense_r} :
    s_axi_araddr == `HSS_POWER_OFS ? {8'h0, power_r} : 32'h0;
  wire rd_ok = s_axi_araddr <= `HSS_POWER_OFS && s_axi_araddr[1:0] == 2'h0;
  wire alert_act = |(alstat_r & alcfg_r[7:0]) & alcfg_r[`HSS_ALCFG_ROUTE_BIT];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= '0;
    end else begin
      s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_val : 32'h0;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // register file and telemetry state
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      por_done_r <= 1'b0;
      current_set_pin_r <= '0;
      addr_r <= `HSS_ADDR_BASE;
      ctrl_r <= {24'h0, `HSS_CURRENT_LIMIT_BITS_RST, 4'h0};
      alcfg_r <= '0;
      alstat_r <= '0;
      flag_r <= '0;
      sense_r <= '0;
      vout_r <= '0;
      temp_r <= '0;
      power_r <= '0;
      for (int i = 0; i < 4; i++) begin
        th_r[i] <= `HSS_TH_RST;
        mm_r[i] <= {12'h0, `HSS_MIN_RST};
      end
    end else begin
      if (por_ok && !por_done_r) begin
        por_done_r <= 1'b1;
        current_set_pin_r <= in_r[`HSS_IN_CURRENT_SET_PIN_LSB +: 3];
        addr_r <= addr_nxt;
        ctrl_r[`HSS_CTRL_ON_BIT] <= in_r[`HSS_IN_START_LOW];
      end else if (wr_ctrl) begin
        ctrl_r <= hss_merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_00f3;
      end
      if (wr_alcfg) begin
        alcfg_r <= hss_merge(alcfg_r, wdata_r, wstrb_r) & 32'h0000_01ff;
      end
      if (wr_th) begin
        th_r[wi[1:0]] <= hss_merge(th_r[wi[1:0]], wdata_r, wstrb_r) & 32'h0fff_0fff;
      end
      flag_r <= (flag_r & ~(wr_stat ? stat_clr[`HSS_STAT_FLAG_LSB +: 2] : 2'h0)) | flag_set;
      alstat_r <= (alstat_r & ~(wr_alstat ? stat_clr[7:0] : 8'h0)) | (adc_done ? cross_nxt : 8'h0);
      if (adc_done) begin
        sense_r <= sense_result;
        vout_r <= vout_result;
        temp_r <= temp_result;
        power_r <= power_nxt;
        mm_r[0] <= hss_minmax(mm_r[0], vout_result);
        mm_r[1] <= hss_minmax(mm_r[1], sense_result);
        mm_r[2] <= hss_minmax(mm_r[2], power_hi);
        mm_r[3] <= hss_minmax(mm_r[3], temp_result);
      end
    end
  end
  // pin and drive outputs
  wire up_nxt = st_nxt == hss_pkg::HSS_RAMP || st_nxt == hss_pkg::HSS_ON;
  wire fault_nxt = st_nxt == hss_pkg::HSS_TMR_DISCHARGE || st_nxt == hss_pkg::HSS_COOLDOWN;
  wire fast_nxt = fast_off | in_r[`HSS_IN_OC3X];
  wire pg_nxt = st_nxt == hss_pkg::HSS_ON && pg_cond;
  wire [3:0] current_limit_bits_nxt = ctrl_r[`HSS_CTRL_SRC_BIT] ? ctrl_r[`HSS_CTRL_CURRENT_LIMIT_BITS_LSB +: 4] : {current_set_pin_r, 1'b1};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gate_pullup_en <= 1'b0;
      gate_pulldown_en <= 1'b1;
      gate_fast_pulldown_en <= 1'b0;
      timer_charge_en <= 1'b0;
      timer_discharge_en <= 1'b0;
      foldback_en <= 1'b0;
      current_limit_code <= `HSS_CURRENT_LIMIT_BITS_RST;
      power_good_pin_o <= 1'b0;
      power_good_pin_oe_b <= 1'b1;
      fault_pin_o <= 1'b0;
      fault_pin_oe_b <= 1'b1;
      alert_pin_o <= 1'b0;
      alert_pin_oe_b <= 1'b1;
      bus_address <= `HSS_ADDR_BASE;
    end else begin
      gate_pullup_en <= up_nxt & ~fast_nxt & vdd_ok;
      gate_pulldown_en <= ~up_nxt & ~fast_nxt;
      gate_fast_pulldown_en <= fast_nxt;
      timer_charge_en <= up_nxt & in_r[`HSS_IN_ACL];
      timer_discharge_en <= st_nxt == hss_pkg::HSS_TMR_DISCHARGE;
      foldback_en <= in_r[`HSS_IN_VDS_HIGH];
      current_limit_code <= current_limit_bits_nxt;
      power_good_pin_oe_b <= ~pg_nxt;
      fault_pin_oe_b <= ~fault_nxt;
      alert_pin_oe_b <= ~alert_act;
      bus_address <= addr_r;
    end
  end
endmodule

// ### hss_map.svh
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH
// timing
`define HSS_CLK_NS 100
`define HSS_DEBOUNCE_US 90600
`define HSS_COOLDOWN_MS 9280
`define HSS_SAMPLE_US 1
`define HSS_FRAME_US 283
// register offsets
`define HSS_CTRL_OFS 8'h00
`define HSS_STAT_OFS 8'h04
`define HSS_ADDR_OFS 8'h08
`define HSS_ALCFG_OFS 8'h0c
`define HSS_ALSTAT_OFS 8'h10
`define HSS_VOUT_MM_OFS 8'h14
`define HSS_SENSE_MM_OFS 8'h18
`define HSS_POWER_MM_OFS 8'h1c
`define HSS_TEMP_MM_OFS 8'h20
`define HSS_VOUT_TH_OFS 8'h24
`define HSS_SENSE_TH_OFS 8'h28
`define HSS_POWER_TH_OFS 8'h2c
`define HSS_TEMP_TH_OFS 8'h30
`define HSS_MEAS_OFS 8'h34
`define HSS_POWER_OFS 8'h38
// fields
`define HSS_CTRL_ON_BIT 0
`define HSS_CTRL_SRC_BIT 1
`define HSS_CTRL_CURRENT_LIMIT_BITS_LSB 4
`define HSS_STAT_FLAG_LSB 8
`define HSS_ALCFG_ROUTE_BIT 8
// reset values
`define HSS_CURRENT_LIMIT_BITS_RST 4'h1
`define HSS_TH_RST 32'h0fff_0000
`define HSS_MIN_RST 12'hfff
`define HSS_ADDR_BASE 7'h40
// synchronised input positions
`define HSS_IN_VDD_OK 0
`define HSS_IN_VDD_LOW 1
`define HSS_IN_INTERNAL_REGULATED_SUPPLY_OK 2
`define HSS_IN_INTERNAL_LOGIC_SUPPLY_OK 3
`define HSS_IN_INTERNAL_REGULATED_SUPPLY_LOW 4
`define HSS_IN_UV 5
`define HSS_IN_OV 6
`define HSS_IN_EN 7
`define HSS_IN_DS_LOW 8
`define HSS_IN_GATE_HIGH 9
`define HSS_IN_FB_OK 10
`define HSS_IN_TMR_HIGH 11
`define HSS_IN_TMR_LOW 12
`define HSS_IN_ACL 13
`define HSS_IN_OC3X 14
`define HSS_IN_VDS_HIGH 15
`define HSS_IN_BADFET 16
`define HSS_IN_START_LOW 17
`define HSS_IN_CURRENT_SET_PIN_LSB 18
`define HSS_IN_ADRL_LSB 21
`define HSS_IN_ADRH_LSB 23
`define HSS_IN_WIDTH 25
`endif

// ### hss_pkg.sv
package hss_pkg;
  typedef enum logic [2:0] {
    HSS_OFF,
    HSS_DEBOUNCE,
    HSS_RAMP,
    HSS_ON,
    HSS_TMR_DISCHARGE,
    HSS_COOLDOWN
  } hss_state_type;
endpackage

// ### hss_sequencer_properties.sv
`timescale 1ns/1ps
module hss_sequencer_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // comparators
  input wire logic [24:0] comparator_in,
  // design outputs
  input wire logic adc_sample_tick,
  input wire logic adc_frame_tick,
  input wire logic gate_pullup_en,
  input wire logic gate_fast_pulldown_en,
  input wire logic timer_charge_en,
  input wire logic timer_discharge_en,
  input wire logic power_good_pin_oe_b,
  input wire logic fault_pin_oe_b,
  input wire logic [6:0] bus_address
);
  logic [11:0] frame_cnt_r;
  logic frame_seen_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      frame_cnt_r <= 12'h000;
      frame_seen_r <= 1'b0;
    end else begin
      frame_cnt_r <= adc_frame_tick ? 12'h000 : frame_cnt_r + 12'h001;
      frame_seen_r <= frame_seen_r | adc_frame_tick;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_supply_low;
    comparator_in[1] [*6];
  endsequence
  sequence s_tick_gap;
    !adc_sample_tick [*8] ##1 !adc_sample_tick ##1 adc_sample_tick;
  endsequence
  property p_fast_pd;
    s_supply_low |-> gate_fast_pulldown_en;
  endproperty
  a_fast_pd: assert property (p_fast_pd) else $error("no fast pulldown on low supply");
  property p_supplies;
    gate_pullup_en |-> comparator_in[0] && comparator_in[2] && comparator_in[3];
  endproperty
  a_supplies: assert property (p_supplies) else $error("gate driven without supplies");
  property p_sample;
    adc_sample_tick |=> s_tick_gap;
  endproperty
  a_sample: assert property (p_sample) else $error("sample tick period wrong");
  property p_frame;
    adc_frame_tick && frame_seen_r |-> frame_cnt_r == 12'd2829;
  endproperty
  a_frame: assert property (p_frame) else $error("frame tick period wrong");
  property p_addr;
    bus_address >= 7'h40 && bus_address <= 7'h48;
  endproperty
  a_addr: assert property (p_addr) else $error("address out of range");
  property p_charge;
    $rose(timer_charge_en) |-> $past(comparator_in[13], 2);
  endproperty
  a_charge: assert property (p_charge) else $error("timer charged without limiting");
  property p_fault_pin;
    $fell(fault_pin_oe_b) |-> $past(comparator_in[11] | comparator_in[16], 2);
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin without cause");
  property p_discharge;
    timer_discharge_en |-> !timer_charge_en && !fault_pin_oe_b && !gate_pullup_en;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge state drives wrong");
  property p_pg;
    $fell(power_good_pin_oe_b) |-> $past(comparator_in[10] & comparator_in[9] & comparator_in[8], 2);
  endproperty
  a_pg: assert property (p_pg) else $error("power good without thresholds");
endmodule
bind hss_sequencer hss_sequencer_properties i_hss_sequencer_properties (.clock, .rst_b, .comparator_in,
  .adc_sample_tick, .adc_frame_tick, .gate_pullup_en, .gate_fast_pulldown_en, .timer_charge_en,
  .timer_discharge_en, .power_good_pin_oe_b, .fault_pin_oe_b, .bus_address);

// ### hss_plant.sv
`timescale 1ns/1ps
module hss_plant (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // levels and drives
  input wire logic [24:0] base,
  input wire logic gate_pullup_en,
  input wire logic gate_pulldown_en,
  input wire logic timer_charge_en,
  input wire logic timer_discharge_en,
  input wire logic fault_pin_oe_b,
  input wire logic adc_frame_tick,
  // comparators and converters
  output logic [24:0] comparator_in,
  output logic adc_done,
  output logic [11:0] sense_result,
  output logic [11:0] vout_result,
  output logic [11:0] temp_result
);
  logic [3:0] gate_r;
  logic [3:0] tmr_r;
  logic gate_hi;
  assign gate_hi = gate_r >= 4'h4;
  // fault pin wired to uv input
  assign comparator_in = {base[24:13], tmr_r == 4'h0, tmr_r >= 4'h8, {3{gate_hi}}, base[7:6],
    base[5] & fault_pin_oe_b, base[4:0]};
  assign sense_result = 12'h123;
  assign vout_result = 12'h010;
  assign temp_result = 12'h019;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gate_r <= 4'h0;
      tmr_r <= 4'h0;
      adc_done <= 1'b0;
    end else begin
      adc_done <= adc_frame_tick;
      if (gate_pulldown_en) gate_r <= 4'h0;
      else if (gate_pullup_en && gate_r != 4'hf) gate_r <= gate_r + 4'h1;
      if (timer_charge_en && tmr_r != 4'h8) tmr_r <= tmr_r + 4'h1;
      else if (timer_discharge_en && tmr_r != 4'h0) tmr_r <= tmr_r - 4'h1;
    end
  end
endmodule

// ### hot_swap_sequencer_bench.sv
`timescale 1ns/1ps
module hot_swap_sequencer_bench;
  logic clock, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, adc_done, adc_sample_tick, adc_frame_tick;
  logic gate_pullup_en, gate_pulldown_en, gate_fast_pulldown_en, timer_charge_en, timer_discharge_en;
  logic foldback_en, power_good_pin_o, power_good_pin_oe_b, fault_pin_o, fault_pin_oe_b, alert_pin_o, alert_pin_oe_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, current_limit_code;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [24:0] comparator_in, base;
  logic [11:0] sense_result, vout_result, temp_result;
  logic [6:0] bus_address;
  int n_fail = 0;
  int n_tests = 0;
  hss_sequencer #(.DEBOUNCE_CYC(20), .COOLDOWN_CYC(30)) i_hss_sequencer (.clock, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .comparator_in, .adc_done, .sense_result, .vout_result, .temp_result,
    .adc_sample_tick, .adc_frame_tick, .gate_pullup_en, .gate_pulldown_en, .gate_fast_pulldown_en,
    .timer_charge_en, .timer_discharge_en, .foldback_en, .current_limit_code, .power_good_pin_o,
    .power_good_pin_oe_b, .fault_pin_o, .fault_pin_oe_b, .alert_pin_o, .alert_pin_oe_b, .bus_address);
  hss_plant i_hss_plant (.clock, .rst_b, .base, .gate_pullup_en, .gate_pulldown_en, .timer_charge_en,
    .timer_discharge_en, .fault_pin_oe_b, .adc_frame_tick, .comparator_in, .adc_done, .sense_result,
    .vout_result, .temp_result);
  always #50 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    n = 0;
    rs = 2'h3;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (rs === 2'h3 && n < 100) begin
      @(posedge clock);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        rs = s_axi_bresp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        rs = s_axi_rresp;
        rd = s_axi_rdata;
      end
    end
    if (rs === 2'h3) begin
      n_fail++;
      $display("BAD %0t bus timeout", $time);
    end
  endtask
  task automatic wait_state(input hss_pkg::hss_state_type s);
    int n;
    n = 0;
    xfer(1'b0, 8'h04, 32'h0);
    while (rd[2:0] !== s && n < 80) begin
      xfer(1'b0, 8'h04, 32'h0);
      n++;
    end
    chk({29'h0, rd[2:0]}, {29'h0, s}, "state");
  endtask
  task automatic t_straps;
    repeat (8) @(posedge clock);
    xfer(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h11, "ctrl");
    chk({28'h0, current_limit_code}, 32'h5, "pin limit");
    xfer(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h47, "address");
    xfer(1'b0, 8'h0c, 32'h0);
    chk({rd[30:0], alert_pin_oe_b}, 32'h1, "alert idle");
    xfer(1'b0, 8'h3c, 32'h0);
    chk({rd[29:0], rs}, 32'h2, "unmapped read");
    xfer(1'b1, 8'h3c, 32'h1);
    chk({30'h0, rs}, 32'h2, "unmapped write");
    wait_state(hss_pkg::HSS_OFF);
    $display("straps done");
  endtask
  task automatic t_on_off;
    base[7] <= 1'b1;
    repeat (14) @(posedge clock);
    wait_state(hss_pkg::HSS_DEBOUNCE);
    wait_state(hss_pkg::HSS_ON);
    chk({30'h0, rd[3], power_good_pin_oe_b}, 32'h2, "power good");
    base[7] <= 1'b0;
    wait_state(hss_pkg::HSS_OFF);
    chk({31'h0, gate_pulldown_en}, 32'h1, "pulldown");
    repeat (6) @(posedge clock);
    chk({31'h0, power_good_pin_oe_b}, 32'h1, "pg release");
    base[7] <= 1'b1;
    wait_state(hss_pkg::HSS_ON);
    base[6] <= 1'b1;
    wait_state(hss_pkg::HSS_OFF);
    base[6] <= 1'b0;
    @(posedge clock);
    base[1] <= 1'b1;
    repeat (6) @(posedge clock);
    chk({31'h0, gate_fast_pulldown_en}, 32'h1, "fast pulldown");
    base[1] <= 1'b0;
    base[14] <= 1'b1;
    repeat (6) @(posedge clock);
    chk({31'h0, gate_fast_pulldown_en}, 32'h1, "3x pulldown");
    base[14] <= 1'b0;
    $display("on off done");
  endtask
  task automatic t_fault;
    int n;
    wait_state(hss_pkg::HSS_ON);
    base[13] <= 1'b1;
    n = 0;
    while (fault_pin_oe_b !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, fault_pin_oe_b}, 32'h0, "fault pin");
    base[13] <= 1'b0;
    xfer(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[8]}, 32'h1, "oc flag");
    wait_state(hss_pkg::HSS_COOLDOWN);
    wait_state(hss_pkg::HSS_ON);
    xfer(1'b1, 8'h04, 32'h100);
    xfer(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[8]}, 32'h0, "flag clear");
    base[16] <= 1'b1;
    wait_state(hss_pkg::HSS_COOLDOWN);
    base[16] <= 1'b0;
    xfer(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[9]}, 32'h1, "bad mosfet flag");
    $display("fault done");
  endtask
  task automatic t_mon;
    xfer(1'b1, 8'h00, 32'hb3);
    base[15] <= 1'b1;
    repeat (6) @(posedge clock);
    chk({27'h0, current_limit_code, foldback_en}, 32'h17, "limit foldback");
    base[15] <= 1'b0;
    repeat (5700) @(posedge clock);
    xfer(1'b0, 8'h38, 32'h0);
    chk(rd, 32'h1230, "power");
    xfer(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h19010123, "latest");
    xfer(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h00100010, "vout min max");
    xfer(1'b1, 8'h24, 32'h000f0000);
    xfer(1'b1, 8'h0c, 32'h102);
    repeat (2900) @(posedge clock);
    xfer(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], alert_pin_oe_b}, 32'h4, "alert");
    $display("monitor done");
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #3000000;
    n_fail++;
    $display("BAD %0t watchdog", $time);
    wrap_up;
  end
  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    base = 25'h12a002d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hf};
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_straps;
    t_on_off;
    t_fault;
    t_mon;
    wrap_up;
  end
endmodule
